//--- hw/ntr_map.svh
// register map, field positions and reset values of the tx count / trim bank
`ifndef NTR_MAP_SVH
`define NTR_MAP_SVH

`define NTR_OFF_TXCNT_HI  8'h1D
`define NTR_OFF_TXCNT_LO  8'h1E
`define NTR_OFF_RATE      8'h1F
`define NTR_OFF_ADC       8'h20
`define NTR_OFF_TRIM_CTL  8'h21
`define NTR_OFF_CAL_DISP  8'h23
`define NTR_OFF_IRQ_STAT  8'h30
`define NTR_OFF_IRQ_EN    8'h31
`define NTR_OFF_IRQ_CLR   8'h32

`define NTR_CNT_LO_MSB    7
`define NTR_CNT_LO_LSB    3
`define NTR_SPLIT_MSB     2
`define NTR_SPLIT_LSB     0
`define NTR_RATE_MSB      7
`define NTR_RATE_LSB      4
`define NTR_TRIM_SEL_BIT  7
`define NTR_TRIM_MAN_MSB  6
`define NTR_TRIM_MAN_LSB  3
`define NTR_CAL_TRI_MSB   7
`define NTR_CAL_TRI_LSB   4
`define NTR_CAL_ERR_BIT   3

`define NTR_RST_BYTE      8'h00
`define NTR_RST_NIB       4'h0
`define NTR_RST_CNT       13'h0000
`define NTR_SPLIT_NONE    3'h0

`define NTR_EVT_NUM       4
`define NTR_EVT_PAR       0
`define NTR_EVT_RATE      1
`define NTR_EVT_ADC       2
`define NTR_EVT_CAL       3

`endif

//--- hw/ntr_pkg.sv
// types shared by the tx count / trim register bank
package ntr_pkg;
  typedef logic [7:0]  ntr_byte_t;
  typedef logic [3:0]  ntr_nib_t;
  typedef logic [12:0] ntr_cnt_t;
  typedef logic [2:0]  ntr_split_t;
endpackage

//--- hw/ntr_evt_if.sv
// carrier between the register bank and its interrupt controller
`timescale 1ns/10ps
interface ntr_evt_if #(
  parameter int W = 4
);
  logic [W-1:0] evt;
  logic         sdef;
  logic         en_we;
  logic         clr_we;
  logic [W-1:0] wdata;
  logic [W-1:0] status;
  logic [W-1:0] enable;
  logic         irq;

  modport regs (
    output evt, sdef, en_we, clr_we, wdata,
    input  status, enable, irq
  );
  modport ctl (
    input  evt, sdef, en_we, clr_we, wdata,
    output status, enable, irq
  );
endinterface

//--- hw/ntr_irq_ctl.sv
// sticky event status, enable mask and level interrupt
`timescale 1ns/10ps
module ntr_irq_ctl
  import ntr_pkg::*;
#(
  parameter int W = 4
) (
  input  wire logic clk_i,
  input  wire logic srst_i,
  ntr_evt_if.ctl    ev
);
  logic [W-1:0] status_r;
  logic [W-1:0] status_nxt;
  logic [W-1:0] enable_r;
  logic [W-1:0] enable_nxt;
  logic         irq_r;

  // set beats clear, so an event in the clearing cycle survives
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_stat
      assign status_nxt[g] = ev.evt[g] |
                             (status_r[g] & ~(ev.clr_we & ev.wdata[g]));
    end
  endgenerate

  always_comb begin
    enable_nxt = ev.en_we ? ev.wdata : enable_r;
  end

  always_ff @(posedge clk_i) begin
    if (srst_i || ev.sdef) begin
      status_r <= '0;
    end else begin
      status_r <= status_nxt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i || ev.sdef) begin
      enable_r <= '0;
    end else begin
      enable_r <= enable_nxt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i || ev.sdef) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(status_nxt & enable_nxt);
    end
  end

  assign ev.status = status_r;
  assign ev.enable = enable_r;
  assign ev.irq    = irq_r;
endmodule

//--- hw/ntr_regs.sv
// tx frame length, rate / adc display and antenna trim register bank
//
// The plain strobed port was decided locally.
`timescale 1ns/10ps
`include "ntr_map.svh"

// Function
// RQ1: 13-bit full byte count across two registers
// RQ2: software keeps byte count at most 8191
// RQ3: low three bits give split byte bits
// RQ4: split byte frame sent without parity bits
// RQ5: anticollision idle split WUPA raises parity error
// RQ6: rw registers zero at reset and default
// RQ7: read-only displays zero at reset and default
// RQ8: detected bit rate code in bits 7..4
// RQ9: latest conversion result replaces previous one
// RQ10: bit 7 picks calibration or manual trim
// RQ11: manual trim bits drive both switch groups
// RQ12: calibration result held, drives switches when auto
// RQ13: trim write reaches switches next cycle
module ntr_regs
  import ntr_pkg::*;
#(
  parameter int EVT_W = `NTR_EVT_NUM
) (
  input  wire logic        CORE_CLK_I,
  input  wire logic        SRST_I,
  input  wire logic [7:0]  ADDR_I,
  input  wire logic [7:0]  WDATA_I,
  input  wire logic        WR_I,
  input  wire logic        RD_I,
  output logic      [7:0]  RDATA_O,
  input  wire logic        SET_DEFAULT_I,
  input  wire logic        RATE_VALID_I,
  input  wire logic [3:0]  RATE_CODE_I,
  input  wire logic        ADC_VALID_I,
  input  wire logic [7:0]  ADC_DATA_I,
  input  wire logic        CAL_DONE_I,
  input  wire logic [3:0]  CAL_TRIM_I,
  input  wire logic        CAL_ERR_I,
  input  wire logic        ANTICOL_I,
  input  wire logic        CARD_IDLE_I,
  input  wire logic        WUPA_CMD_I,
  output logic      [12:0] TX_BYTE_COUNT_O,
  output logic      [2:0]  TX_SPLIT_BITS_O,
  output logic             TX_PARITY_EN_O,
  output logic             PARITY_ERR_O,
  output logic      [3:0]  TRIM_SWITCH_GROUP_ONE_O,
  output logic      [3:0]  TRIM_SWITCH_GROUP_TWO_O,
  output logic             IRQ_O
);

  function automatic logic addr_hit(
    input ntr_byte_t addr,
    input ntr_byte_t off
  );
    addr_hit = (addr == off);
  endfunction

  ntr_byte_t  cnt_hi_r;
  ntr_byte_t  cnt_hi_nxt;
  ntr_byte_t  cnt_lo_r;
  ntr_byte_t  cnt_lo_nxt;
  ntr_nib_t   rate_r;
  ntr_nib_t   rate_nxt;
  ntr_byte_t  adc_r;
  ntr_byte_t  adc_nxt;
  logic       trim_sel_r;
  logic       trim_sel_nxt;
  ntr_nib_t   trim_man_r;
  ntr_nib_t   trim_man_nxt;
  ntr_nib_t   cal_tri_r;
  ntr_nib_t   cal_tri_nxt;
  logic       cal_err_r;
  logic       cal_err_nxt;
  ntr_nib_t   trim_drive_nxt;
  ntr_nib_t   trim_one_r;
  ntr_nib_t   trim_two_r;
  ntr_cnt_t   tx_cnt_r;
  ntr_cnt_t   tx_cnt_nxt;
  ntr_split_t tx_split_r;
  ntr_split_t tx_split_nxt;
  logic       tx_par_en_r;
  logic       tx_par_en_nxt;
  logic       par_err_r;
  logic       par_err_nxt;
  ntr_byte_t  rdata_r;
  ntr_byte_t  rdata_nxt;
  logic       wr_cnt_hi;
  logic       wr_cnt_lo;
  logic       wr_trim;
  logic       wr_irq_en;
  logic       wr_irq_clr;
  logic       clr_all;

  ntr_evt_if #(.W(EVT_W)) evt_bus ();

  // set default acts like a reset on every register of the bank except the read data register
  assign clr_all = SRST_I | SET_DEFAULT_I;

  always_comb begin
    wr_cnt_hi  = WR_I & addr_hit(ADDR_I, `NTR_OFF_TXCNT_HI);
    wr_cnt_lo  = WR_I & addr_hit(ADDR_I, `NTR_OFF_TXCNT_LO);
    wr_trim    = WR_I & addr_hit(ADDR_I, `NTR_OFF_TRIM_CTL);
    wr_irq_en  = WR_I & addr_hit(ADDR_I, `NTR_OFF_IRQ_EN);
    wr_irq_clr = WR_I & addr_hit(ADDR_I, `NTR_OFF_IRQ_CLR);
  end

  always_comb begin
    cnt_hi_nxt = wr_cnt_hi ? WDATA_I : cnt_hi_r;
  end

  always_comb begin
    cnt_lo_nxt = wr_cnt_lo ? WDATA_I : cnt_lo_r;
  end

  // byte count register, upper eight count bits
  always_ff @(posedge CORE_CLK_I) begin
    if (clr_all) begin
      cnt_hi_r <= `NTR_RST_BYTE; // RQ6
    end else begin
      cnt_hi_r <= cnt_hi_nxt; // RQ1
    end
  end

  // lower five count bits and split byte bit count
  always_ff @(posedge CORE_CLK_I) begin
    if (clr_all) begin
      cnt_lo_r <= `NTR_RST_BYTE; // RQ6
    end else begin
      cnt_lo_r <= cnt_lo_nxt; // RQ1
    end
  end

  always_comb begin
    tx_cnt_nxt = {cnt_hi_nxt,
                  cnt_lo_nxt[`NTR_CNT_LO_MSB:`NTR_CNT_LO_LSB]}; // RQ1
  end

  always_comb begin
    tx_split_nxt = cnt_lo_nxt[`NTR_SPLIT_MSB:`NTR_SPLIT_LSB]; // RQ3
  end

  // parity generation only for frames made of complete bytes
  always_comb begin
    tx_par_en_nxt = (tx_split_nxt == `NTR_SPLIT_NONE); // RQ4
  end

  // count is not range checked; software keeps it in the frame limit
  always_ff @(posedge CORE_CLK_I) begin
    if (clr_all) begin
      tx_cnt_r <= `NTR_RST_CNT;
    end else begin
      tx_cnt_r <= tx_cnt_nxt; // RQ1 RQ2
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (clr_all) begin
      tx_split_r <= `NTR_SPLIT_NONE;
    end else begin
      tx_split_r <= tx_split_nxt; // RQ3
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (clr_all) begin
      tx_par_en_r <= 1'b1;
    end else begin
      tx_par_en_r <= tx_par_en_nxt; // RQ4
    end
  end

  // a wake-up command in anticollision with the card idle and a split byte pending is a parity fault
  always_comb begin
    par_err_nxt = WUPA_CMD_I & ANTICOL_I & CARD_IDLE_I &
                  (tx_split_r != `NTR_SPLIT_NONE); // RQ5
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (clr_all) begin
      par_err_r <= 1'b0;
    end else begin
      par_err_r <= par_err_nxt; // RQ5
    end
  end

  always_comb begin
    rate_nxt = RATE_VALID_I ? RATE_CODE_I : rate_r;
  end

  // detected bit rate, kept until the next detection
  always_ff @(posedge CORE_CLK_I) begin
    if (clr_all) begin
      rate_r <= `NTR_RST_NIB; // RQ7
    end else begin
      rate_r <= rate_nxt; // RQ8
    end
  end

  always_comb begin
    adc_nxt = ADC_VALID_I ? ADC_DATA_I : adc_r;
  end

  // conversion result, overwritten by each new conversion
  always_ff @(posedge CORE_CLK_I) begin
    if (clr_all) begin
      adc_r <= `NTR_RST_BYTE; // RQ7
    end else begin
      adc_r <= adc_nxt; // RQ9
    end
  end

  always_comb begin
    cal_tri_nxt = CAL_DONE_I ? CAL_TRIM_I : cal_tri_r;
  end

  always_comb begin
    cal_err_nxt = CAL_DONE_I ? CAL_ERR_I : cal_err_r;
  end

  // calibration outcome, held until the next calibration run
  always_ff @(posedge CORE_CLK_I) begin
    if (clr_all) begin
      cal_tri_r <= `NTR_RST_NIB;
    end else begin
      cal_tri_r <= cal_tri_nxt; // RQ12
    end
  end

  // error flag of the same run, updated together with the result
  always_ff @(posedge CORE_CLK_I) begin
    if (clr_all) begin
      cal_err_r <= 1'b0;
    end else begin
      cal_err_r <= cal_err_nxt;
    end
  end

  always_comb begin
    trim_sel_nxt = wr_trim ? WDATA_I[`NTR_TRIM_SEL_BIT] : trim_sel_r;
    trim_man_nxt = wr_trim ?
                   WDATA_I[`NTR_TRIM_MAN_MSB:`NTR_TRIM_MAN_LSB] :
                   trim_man_r;
  end

  // trim control; unused low bits are not stored and read zero
  always_ff @(posedge CORE_CLK_I) begin
    if (clr_all) begin
      trim_sel_r <= 1'b0; // RQ6
    end else begin
      trim_sel_r <= trim_sel_nxt; // RQ10
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (clr_all) begin
      trim_man_r <= `NTR_RST_NIB; // RQ6
    end else begin
      trim_man_r <= trim_man_nxt; // RQ11
    end
  end

  always_comb begin
    if (trim_sel_nxt) begin
      trim_drive_nxt = trim_man_nxt; // RQ10 RQ11
    end else begin
      trim_drive_nxt = cal_tri_nxt; // RQ10 RQ12
    end
  end

  // built from next values so a write shows one edge later
  always_ff @(posedge CORE_CLK_I) begin
    if (clr_all) begin
      trim_one_r <= `NTR_RST_NIB;
    end else begin
      trim_one_r <= trim_drive_nxt; // RQ11 RQ13
    end
  end

  // second pin group carries the same drive
  always_ff @(posedge CORE_CLK_I) begin
    if (clr_all) begin
      trim_two_r <= `NTR_RST_NIB;
    end else begin
      trim_two_r <= trim_drive_nxt; // RQ11 RQ13
    end
  end

  always_comb begin
    evt_bus.evt                = '0;
    evt_bus.evt[`NTR_EVT_PAR]  = par_err_nxt;
    evt_bus.evt[`NTR_EVT_RATE] = RATE_VALID_I;
    evt_bus.evt[`NTR_EVT_ADC]  = ADC_VALID_I;
    evt_bus.evt[`NTR_EVT_CAL]  = CAL_DONE_I;
    evt_bus.sdef               = SET_DEFAULT_I;
    evt_bus.en_we              = wr_irq_en;
    evt_bus.clr_we             = wr_irq_clr;
    evt_bus.wdata              = WDATA_I[EVT_W-1:0];
  end

  ntr_irq_ctl #(
    .W      (EVT_W)
  ) u_irq (
    .clk_i  (CORE_CLK_I),
    .srst_i (SRST_I),
    .ev     (evt_bus.ctl)
  );

  // read mux; unmapped and write-only offsets read zero
  always_comb begin
    rdata_nxt = `NTR_RST_BYTE;
    if (!RD_I) begin
      rdata_nxt = `NTR_RST_BYTE;
    end else if (addr_hit(ADDR_I, `NTR_OFF_TXCNT_HI)) begin
      rdata_nxt = cnt_hi_r;
    end else if (addr_hit(ADDR_I, `NTR_OFF_TXCNT_LO)) begin
      rdata_nxt = cnt_lo_r;
    end else if (addr_hit(ADDR_I, `NTR_OFF_RATE)) begin
      rdata_nxt[`NTR_RATE_MSB:`NTR_RATE_LSB] = rate_r; // RQ8
    end else if (addr_hit(ADDR_I, `NTR_OFF_ADC)) begin
      rdata_nxt = adc_r; // RQ9
    end else if (addr_hit(ADDR_I, `NTR_OFF_TRIM_CTL)) begin
      rdata_nxt[`NTR_TRIM_SEL_BIT] = trim_sel_r;
      rdata_nxt[`NTR_TRIM_MAN_MSB:`NTR_TRIM_MAN_LSB] = trim_man_r;
    end else if (addr_hit(ADDR_I, `NTR_OFF_CAL_DISP)) begin
      rdata_nxt[`NTR_CAL_TRI_MSB:`NTR_CAL_TRI_LSB] = cal_tri_r; // RQ12
      rdata_nxt[`NTR_CAL_ERR_BIT] = cal_err_r;
    end else if (addr_hit(ADDR_I, `NTR_OFF_IRQ_STAT)) begin
      rdata_nxt[EVT_W-1:0] = evt_bus.status;
    end else if (addr_hit(ADDR_I, `NTR_OFF_IRQ_EN)) begin
      rdata_nxt[EVT_W-1:0] = evt_bus.enable;
    end
  end

  // data stand only in the cycle after the read strobe
  always_ff @(posedge CORE_CLK_I) begin
    if (SRST_I) begin
      rdata_r <= `NTR_RST_BYTE;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign RDATA_O                 = rdata_r;
  assign TX_BYTE_COUNT_O         = tx_cnt_r;
  assign TX_SPLIT_BITS_O         = tx_split_r;
  assign TX_PARITY_EN_O          = tx_par_en_r;
  assign PARITY_ERR_O            = par_err_r;
  assign TRIM_SWITCH_GROUP_ONE_O = trim_one_r;
  assign TRIM_SWITCH_GROUP_TWO_O = trim_two_r;
  assign IRQ_O                   = evt_bus.irq;

endmodule

//--- bench/ntr_regs_sva.sv
// port assertions of the tx count / trim register bank
`timescale 1ns/10ps
module ntr_regs_sva (
  input wire logic        CORE_CLK_I,
  input wire logic        SRST_I,
  input wire logic [7:0]  ADDR_I,
  input wire logic [7:0]  WDATA_I,
  input wire logic        WR_I,
  input wire logic        RD_I,
  input wire logic [7:0]  RDATA_O,
  input wire logic        SET_DEFAULT_I,
  input wire logic        ANTICOL_I,
  input wire logic        CARD_IDLE_I,
  input wire logic        WUPA_CMD_I,
  input wire logic [12:0] TX_BYTE_COUNT_O,
  input wire logic [2:0]  TX_SPLIT_BITS_O,
  input wire logic        TX_PARITY_EN_O,
  input wire logic        PARITY_ERR_O,
  input wire logic [3:0]  TRIM_SWITCH_GROUP_ONE_O,
  input wire logic [3:0]  TRIM_SWITCH_GROUP_TWO_O,
  input wire logic        IRQ_O
);
  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (SRST_I);
  logic wq;
  assign wq = WR_I && !SET_DEFAULT_I;
  a_rdata_idle: assert property (!$past(RD_I) |-> RDATA_O == 8'h00)
    else $error("read data not zero outside read slot");
  a_parity_follows_split: assert property (
    TX_PARITY_EN_O == (TX_SPLIT_BITS_O == 3'h0))
    else $error("parity enable disagrees with split count");
  a_trim_groups_equal: assert property (
    TRIM_SWITCH_GROUP_ONE_O == TRIM_SWITCH_GROUP_TWO_O)
    else $error("trim groups differ");
  a_wupa_parity_err: assert property (ANTICOL_I && CARD_IDLE_I &&
    TX_SPLIT_BITS_O != 3'h0 && WUPA_CMD_I && !SET_DEFAULT_I
    |=> PARITY_ERR_O)
    else $error("parity error pulse missing");
  a_parity_err_cause: assert property (!WUPA_CMD_I |=> !PARITY_ERR_O)
    else $error("parity error without wake-up");
  a_count_high_wr: assert property (wq && ADDR_I == 8'h1D |=>
    TX_BYTE_COUNT_O[12:5] == $past(WDATA_I))
    else $error("count high bits not written");
  a_count_low_wr: assert property (wq && ADDR_I == 8'h1E |=>
    {TX_BYTE_COUNT_O[4:0], TX_SPLIT_BITS_O} == $past(WDATA_I))
    else $error("count low or split not written");
  a_trim_manual_wr: assert property (wq && ADDR_I == 8'h21 &&
    WDATA_I[7] |=> TRIM_SWITCH_GROUP_ONE_O == $past(WDATA_I[6:3]))
    else $error("manual trim not applied next cycle");
  a_default_clears: assert property (SET_DEFAULT_I |=>
    TX_BYTE_COUNT_O == 13'h0000 && TRIM_SWITCH_GROUP_ONE_O == 4'h0 && !IRQ_O)
    else $error("set default left state");
  c_parity_err: cover property (PARITY_ERR_O && IRQ_O);
  c_manual_trim: cover property (wq && ADDR_I == 8'h21 && WDATA_I[7]);
  c_default: cover property (SET_DEFAULT_I);
endmodule

bind ntr_regs ntr_regs_sva u_sva (.CORE_CLK_I, .SRST_I, .ADDR_I, .WDATA_I,
  .WR_I, .RD_I, .RDATA_O, .SET_DEFAULT_I, .ANTICOL_I, .CARD_IDLE_I,
  .WUPA_CMD_I, .TX_BYTE_COUNT_O, .TX_SPLIT_BITS_O, .TX_PARITY_EN_O,
  .PARITY_ERR_O, .TRIM_SWITCH_GROUP_ONE_O, .TRIM_SWITCH_GROUP_TWO_O, .IRQ_O);

//--- bench/ntr_regs_tb_top.sv
// directed bench of the tx count / trim register bank
`timescale 1ns/10ps
module ntr_regs_tb_top;
  logic        CORE_CLK_I, SRST_I, WR_I, RD_I, SET_DEFAULT_I;
  logic [7:0]  ADDR_I, WDATA_I, RDATA_O, ADC_DATA_I;
  logic        RATE_VALID_I, ADC_VALID_I, CAL_DONE_I, CAL_ERR_I;
  logic [3:0]  RATE_CODE_I, CAL_TRIM_I;
  logic        ANTICOL_I, CARD_IDLE_I, WUPA_CMD_I;
  logic [12:0] TX_BYTE_COUNT_O;
  logic [2:0]  TX_SPLIT_BITS_O;
  logic        TX_PARITY_EN_O, PARITY_ERR_O, IRQ_O;
  logic [3:0]  TRIM_SWITCH_GROUP_ONE_O, TRIM_SWITCH_GROUP_TWO_O;
  int          bad_count, check_count, cyc;

  ntr_regs uut (.CORE_CLK_I, .SRST_I, .ADDR_I, .WDATA_I, .WR_I, .RD_I,
    .RDATA_O, .SET_DEFAULT_I, .RATE_VALID_I, .RATE_CODE_I, .ADC_VALID_I,
    .ADC_DATA_I, .CAL_DONE_I, .CAL_TRIM_I, .CAL_ERR_I, .ANTICOL_I,
    .CARD_IDLE_I, .WUPA_CMD_I, .TX_BYTE_COUNT_O, .TX_SPLIT_BITS_O,
    .TX_PARITY_EN_O, .PARITY_ERR_O, .TRIM_SWITCH_GROUP_ONE_O,
    .TRIM_SWITCH_GROUP_TWO_O, .IRQ_O);

  initial begin
    CORE_CLK_I = 1'b0;
    forever #20 CORE_CLK_I = ~CORE_CLK_I;
  end

  task automatic chk(input string n, input logic [12:0] s,
                     input logic [12:0] e);
    check_count++;
    if (s !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge CORE_CLK_I);
    ADDR_I  <= a;
    WDATA_I <= d;
    WR_I    <= 1'b1;
    @(posedge CORE_CLK_I);
    WR_I <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge CORE_CLK_I);
    ADDR_I <= a;
    RD_I   <= 1'b1;
    @(posedge CORE_CLK_I);
    RD_I <= 1'b0;
    #1;
    chk($sformatf("reg %h", a), RDATA_O, e);
  endtask

  task automatic wupa();
    @(posedge CORE_CLK_I) WUPA_CMD_I <= 1'b1;
    @(posedge CORE_CLK_I) WUPA_CMD_I <= 1'b0;
    #1;
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // whole run needs well under 400 cycles
  always @(posedge CORE_CLK_I) begin
    cyc++;
    if (cyc == 2000) begin
      bad_count++;
      test_done();
    end
  end

  initial begin
    SRST_I = 1'b1;
    {WR_I, RD_I, SET_DEFAULT_I, RATE_VALID_I} = 4'h0;
    {ADC_VALID_I, CAL_DONE_I, CAL_ERR_I, ANTICOL_I, CARD_IDLE_I} = 5'h00;
    {ADDR_I, WDATA_I, ADC_DATA_I, RATE_CODE_I, CAL_TRIM_I} = 32'h0000_0000;
    WUPA_CMD_I = 1'b0;
    repeat (3) @(posedge CORE_CLK_I);
    SRST_I <= 1'b0;
    #1;
    rd(8'h1D, 8'h00);
    rd(8'h1E, 8'h00);
    rd(8'h1F, 8'h00);
    rd(8'h20, 8'h00);
    rd(8'h21, 8'h00);
    chk("parity en", TX_PARITY_EN_O, 13'h0001);
    $display("test reset done");
    wr(8'h1D, 8'hFF);
    wr(8'h1E, 8'hFD);
    chk("count", TX_BYTE_COUNT_O, 13'h1FFF);
    chk("split", TX_SPLIT_BITS_O, 13'h0005);
    chk("parity en", TX_PARITY_EN_O, 13'h0000);
    rd(8'h1E, 8'hFD);
    wr(8'h1E, 8'hF8);
    chk("parity en", TX_PARITY_EN_O, 13'h0001);
    $display("test count done");
    wr(8'h1F, 8'hAA);
    wr(8'h20, 8'h55);
    rd(8'h1F, 8'h00);
    @(posedge CORE_CLK_I) {RATE_VALID_I, RATE_CODE_I} <= 5'h1A;
    @(posedge CORE_CLK_I) RATE_VALID_I <= 1'b0;
    rd(8'h1F, 8'hA0);
    @(posedge CORE_CLK_I) {ADC_VALID_I, ADC_DATA_I} <= 9'h13C;
    @(posedge CORE_CLK_I) ADC_DATA_I <= 8'hC3;
    @(posedge CORE_CLK_I) ADC_VALID_I <= 1'b0;
    rd(8'h20, 8'hC3);
    rd(8'h40, 8'h00);
    $display("test display done");
    @(posedge CORE_CLK_I) {CAL_DONE_I, CAL_TRIM_I, CAL_ERR_I} <= 6'h33;
    @(posedge CORE_CLK_I) CAL_DONE_I <= 1'b0;
    #1;
    chk("trim cal", TRIM_SWITCH_GROUP_ONE_O, 13'h0009);
    rd(8'h23, 8'h98);
    wr(8'h21, 8'hB0);
    chk("trim man", TRIM_SWITCH_GROUP_TWO_O, 13'h0006);
    rd(8'h21, 8'hB0);
    wr(8'h21, 8'h30);
    chk("trim auto", TRIM_SWITCH_GROUP_ONE_O, 13'h0009);
    $display("test trim done");
    wr(8'h31, 8'h01);
    wr(8'h1E, 8'h01);
    @(posedge CORE_CLK_I) {ANTICOL_I, CARD_IDLE_I} <= 2'h3;
    wupa();
    chk("parity err", PARITY_ERR_O, 13'h0001);
    chk("irq", IRQ_O, 13'h0001);
    rd(8'h30, 8'h0F);
    wr(8'h32, 8'h01);
    chk("irq clr", IRQ_O, 13'h0000);
    @(posedge CORE_CLK_I) CARD_IDLE_I <= 1'b0;
    wupa();
    chk("no err", PARITY_ERR_O, 13'h0000);
    $display("test parity done");
    @(posedge CORE_CLK_I) SET_DEFAULT_I <= 1'b1;
    @(posedge CORE_CLK_I) SET_DEFAULT_I <= 1'b0;
    rd(8'h1D, 8'h00);
    rd(8'h1E, 8'h00);
    rd(8'h1F, 8'h00);
    rd(8'h20, 8'h00);
    rd(8'h21, 8'h00);
    $display("test default done");
    test_done();
  end
endmodule
